// ===== lca_top.sv
// Purpose: detection, transmit delay and central warning control of a crossing alert
// Assumes: confirmation and far-side report arrive as levels from the radio receiver
// Notes: the warning ends on far-side report or cutoff expiry, whichever comes first
`timescale 1ns/100ps
module lca_top #(
	parameter int unsigned TX_DELAY_CYCLES = lca_pkg::TX_DELAY_CYC
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Sensors
	input wire logic track_active_in,
	input wire logic sound_is_train_in,
	input wire logic motion_in,
	input wire logic [lca_pkg::LEN_W-1:0] length_m_in,
	// Radio link
	output logic tx_key_out,
	input wire logic confirm_in,
	input wire logic far_report_in,
	// User setting
	input wire logic [lca_pkg::CUT_W-1:0] cutoff_cycles_in,
	// Warning outputs, side A and side B
	output logic flash_a_out,
	output logic flash_b_out,
	output logic buzzer_a_out,
	output logic buzzer_b_out,
	output logic scroll_a_out,
	output logic scroll_b_out,
	output logic timer_run_out
);
	localparam logic [lca_pkg::DLY_W-1:0] DLY_LAST = lca_pkg::DLY_W'(TX_DELAY_CYCLES - 1);
	localparam logic [lca_pkg::LEN_W-1:0] MIN_LEN = lca_pkg::LEN_W'(lca_pkg::MIN_TRAIN_LEN_M);
	localparam logic [lca_pkg::CUT_W-1:0] CUT_ONE = lca_pkg::CUT_W'(1);
	localparam logic [lca_pkg::DLY_W-1:0] DLY_ONE = lca_pkg::DLY_W'(1);
	localparam logic [lca_pkg::CUT_W-1:0] CUT_ZERO = '0;
	localparam logic [lca_pkg::DLY_W-1:0] DLY_ZERO = '0;

	// Two-stage synchronisers for every external level except rst_n_in, which is used directly
	logic [4:0] s1_reg;
	logic [4:0] s2_reg;
	logic [lca_pkg::LEN_W-1:0] l1_reg;
	logic [lca_pkg::LEN_W-1:0] l2_reg;
	// Cutoff setting is static; changing it as a warning starts may load a torn value
	logic [lca_pkg::CUT_W-1:0] c1_reg;
	logic [lca_pkg::CUT_W-1:0] c2_reg;
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			s1_reg <= '0;
			s2_reg <= '0;
			l1_reg <= '0;
			l2_reg <= '0;
			c1_reg <= CUT_ZERO;
			c2_reg <= CUT_ZERO;
		end else begin
			s1_reg <= {far_report_in, confirm_in, motion_in, sound_is_train_in, track_active_in};
			s2_reg <= s1_reg;
			l1_reg <= length_m_in;
			l2_reg <= l1_reg;
			c1_reg <= cutoff_cycles_in;
			c2_reg <= c1_reg;
		end
	end
	logic track_s, sound_s, motion_s, confirm_s, far_s;
	assign track_s = s2_reg[0];
	assign sound_s = s2_reg[1];
	assign motion_s = s2_reg[2];
	assign confirm_s = s2_reg[3];
	assign far_s = s2_reg[4];

	logic qualify;
	assign qualify = sound_s && motion_s && (l2_reg >= MIN_LEN);

	lca_pkg::lca_det_t det_reg;
	logic [lca_pkg::DLY_W-1:0] dly_reg;
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			det_reg <= lca_pkg::LCA_IDLE;
			dly_reg <= DLY_ZERO;
		end else begin
			case (det_reg)
				lca_pkg::LCA_IDLE: begin
					if (track_s) begin
						det_reg <= lca_pkg::LCA_QUAL;
					end
				end
				lca_pkg::LCA_QUAL: begin
					dly_reg <= DLY_ZERO;
					if (!track_s) begin
						det_reg <= lca_pkg::LCA_IDLE;
					end else if (qualify) begin
						det_reg <= lca_pkg::LCA_WAIT;
					end
				end
				lca_pkg::LCA_WAIT: begin
					if (!qualify) begin
						det_reg <= lca_pkg::LCA_QUAL;
					end else if (dly_reg == DLY_LAST) begin
						det_reg <= lca_pkg::LCA_SEND;
					end else begin
						dly_reg <= dly_reg + DLY_ONE;
					end
				end
				lca_pkg::LCA_SEND: begin
					if (confirm_s) begin
						det_reg <= lca_pkg::LCA_IDLE;
					end
				end
				default: det_reg <= lca_pkg::LCA_IDLE;
			endcase
		end
	end
	assign tx_key_out = (det_reg == lca_pkg::LCA_SEND);

	lca_pkg::lca_ctl_t ctl_reg;
	logic [lca_pkg::CUT_W-1:0] cut_reg;
	logic warn_reg;
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			ctl_reg <= lca_pkg::LCA_READY;
			cut_reg <= CUT_ZERO;
			warn_reg <= 1'b0;
		end else begin
			case (ctl_reg)
				lca_pkg::LCA_READY: begin
					if (confirm_s) begin
						ctl_reg <= lca_pkg::LCA_WARN;
						cut_reg <= c2_reg;
						warn_reg <= 1'b1;
					end
				end
				// end on far report or expiry
				lca_pkg::LCA_WARN: begin
					if (far_s || cut_reg <= CUT_ONE) begin
						ctl_reg <= lca_pkg::LCA_HOLD;
						warn_reg <= 1'b0;
						cut_reg <= CUT_ZERO;
					end else begin
						cut_reg <= cut_reg - CUT_ONE;
					end
				end
				// Wait for confirm to drop so one message gives one warning
				lca_pkg::LCA_HOLD: begin
					if (!confirm_s) begin
						ctl_reg <= lca_pkg::LCA_READY;
					end
				end
				default: ctl_reg <= lca_pkg::LCA_READY;
			endcase
		end
	end

	assign flash_a_out = warn_reg;
	assign flash_b_out = warn_reg;
	assign buzzer_a_out = warn_reg;
	assign buzzer_b_out = warn_reg;
	assign scroll_a_out = warn_reg;
	assign scroll_b_out = warn_reg;
	assign timer_run_out = (ctl_reg == lca_pkg::LCA_WARN);

	sequence confirm_rise_s;
		$rose(confirm_s) && ctl_reg == lca_pkg::LCA_READY;
	endsequence
	sequence warn_on_s;
		warn_reg && timer_run_out;
	endsequence

	warn_start_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		confirm_rise_s |=> warn_on_s) else $error("warning did not start on confirm");
	far_stop_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(warn_reg && far_s) |=> !warn_reg) else $error("warning not ended by far report");
	cut_stop_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(warn_reg && cut_reg == CUT_ONE) |=> !warn_reg) else $error("cutoff expiry ignored");
	timer_load_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		confirm_rise_s |=> cut_reg == $past(c2_reg)) else $error("cutoff not loaded");
	outs_equal_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		flash_a_out == buzzer_b_out && scroll_a_out == flash_b_out && buzzer_a_out == scroll_b_out
		&& flash_a_out == timer_run_out)
		else $error("warning outputs disagree");
	tx_delay_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		$rose(tx_key_out) |-> $past(det_reg) == lca_pkg::LCA_WAIT && $past(dly_reg) == DLY_LAST)
		else $error("transmitter keyed without full delay");
	qual_need_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(det_reg == lca_pkg::LCA_QUAL && !(sound_s && l2_reg >= MIN_LEN)) |=>
		det_reg != lca_pkg::LCA_WAIT) else $error("non-train qualified");
	track_gate_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(det_reg == lca_pkg::LCA_IDLE && !track_s) |=> det_reg == lca_pkg::LCA_IDLE)
		else $error("detection left idle without track");
	valid_conf_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		$rose(warn_reg) |-> $past(confirm_s)) else $error("warning without confirmation");
	det_start_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(det_reg == lca_pkg::LCA_IDLE && track_s) |=> det_reg == lca_pkg::LCA_QUAL)
		else $error("track did not start detection");
	warn_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(warn_reg && !far_s && cut_reg > CUT_ONE) |=> warn_reg)
		else $error("warning dropped early");
	tx_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(tx_key_out && !confirm_s) |=> tx_key_out) else $error("keying stopped before confirm");
	reset_quiet_a: assert property (@(posedge sys_clk_in)
		!rst_n_in |=> !warn_reg && !timer_run_out && !tx_key_out) else $error("not quiet after reset");
endmodule : lca_top

// ===== lca_pkg.sv
// Purpose: constants and types for the crossing alert control
// Assumes: 20 MHz system clock
// Notes: sensor and radio levels arrive from outside and are synchronised
package lca_pkg;
	localparam int unsigned CLK_HZ = 20000000;
	// Transmit delay in milliseconds, as specified
	localparam int unsigned TX_DELAY_MS = 1500;
	localparam int unsigned TX_DELAY_CYC = (CLK_HZ / 1000) * TX_DELAY_MS;
	localparam int unsigned MIN_TRAIN_LEN_M = 10;
	localparam int LEN_W = 8;
	localparam int CUT_W = 32;
	localparam int DLY_W = 32;
	typedef enum logic [3:0] {
		LCA_IDLE = 4'h1,
		LCA_QUAL = 4'h2,
		LCA_WAIT = 4'h4,
		LCA_SEND = 4'h8
	} lca_det_t;
	typedef enum logic [2:0] {
		LCA_READY = 3'h1,
		LCA_WARN = 3'h2,
		LCA_HOLD = 3'h4
	} lca_ctl_t;
endpackage : lca_pkg

// ===== lca_rx_model.sv
// Purpose: central receiver model answering the transmit key
// Assumes: confirm is a level, held until the warning ends
// Notes: lat_in sets a prompt or slow answer
`timescale 1ns/100ps
module lca_rx_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Link
	input wire logic tx_key_in,
	input wire logic warn_in,
	input wire logic [3:0] lat_in,
	output logic confirm_out
);
	logic [3:0] cnt_reg;
	logic seen_reg;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || !tx_key_in) cnt_reg <= 4'h0;
		else if (cnt_reg != 4'hf) cnt_reg <= cnt_reg + 4'h1;
	end
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || (seen_reg && !warn_in)) begin
			confirm_out <= 1'b0;
			seen_reg <= 1'b0;
		end else begin
			if (tx_key_in && cnt_reg >= lat_in) confirm_out <= 1'b1;
			if (warn_in) seen_reg <= 1'b1;
		end
	end
endmodule : lca_rx_model

// ===== tb_top.sv
// Purpose: self-checking bench for the crossing alert control
// Assumes: short transmit delay parameter
// Notes: outputs are read at the edge, before that edge's updates land
`timescale 1ns/100ps
module tb_top;
	localparam int D = 20;
	logic sys_clk_in = 1'b0, rst_n_in = 1'b0, track = 1'b0, sound = 1'b0, motion = 1'b0;
	logic far = 1'b0, tx_key, confirm, fa, fb, ba, bb, sa, sb, trun, q;
	logic [7:0] len = 8'h00;
	logic [31:0] cutoff = 32'h0000_0001;
	logic [3:0] lat = 4'h0;
	logic [5:0] warn;
	int fail_count = 0, num_checks = 0, n;
	assign warn = {fa, fb, ba, bb, sa, sb};
	always #25 sys_clk_in = ~sys_clk_in;
	lca_top #(.TX_DELAY_CYCLES(D)) uut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
		.track_active_in(track), .sound_is_train_in(sound), .motion_in(motion),
		.length_m_in(len), .tx_key_out(tx_key), .confirm_in(confirm), .far_report_in(far),
		.cutoff_cycles_in(cutoff), .flash_a_out(fa), .flash_b_out(fb), .buzzer_a_out(ba),
		.buzzer_b_out(bb), .scroll_a_out(sa), .scroll_b_out(sb), .timer_run_out(trun));
	lca_rx_model rx (.clk_in(sys_clk_in), .rst_n_in(rst_n_in), .tx_key_in(tx_key),
		.warn_in(fa), .lat_in(lat), .confirm_out(confirm));
	function automatic logic qual(logic t, logic [7:0] l, logic s, logic m);
		return t && s && m && (l >= 8'h0a);
	endfunction : qual
	// A zero cutoff still gives one cycle of warning
	function automatic logic [31:0] exp_cut(logic [31:0] c);
		return (c == 32'h0) ? 32'h1 : c;
	endfunction : exp_cut
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (e !== g) begin
			fail_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : results
	// Hang guard, well beyond eight trips
	initial begin
		#250000;
		fail_count++;
		results();
	end
	initial begin
		void'($urandom(52));
		repeat (8) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		@(posedge sys_clk_in);
		chk("idle", 32'h0, {tx_key, trun, warn});
		for (int i = 0; i < 8; i++) begin
			// Corners: short, exact and long trains, missing sound, motion or track
			sound <= (i != 3) && (i < 3 || i == 6 || 1'($urandom_range(1)));
			motion <= (i != 4) && (i < 3 || i == 6 || 1'($urandom_range(1)));
			len <= (i == 0) ? 8'h09 : (i == 1) ? 8'h0a : (i < 6) ? 8'hff :
				(i == 6) ? 8'($urandom_range(30, 10)) : 8'($urandom_range(30));
			lat <= 4'($urandom_range(9));
			cutoff <= i[0] ? 32'h0000_00c8 : (i == 2) ? 32'h0 : 32'($urandom_range(30, 3));
			track <= (i != 5);
			@(posedge sys_clk_in);
			q = qual(track, len, sound, motion);
			n = 0;
			while (!tx_key && n < D + 12) begin
				@(posedge sys_clk_in);
				n++;
			end
			chk("tx_key", q, tx_key);
			if (!q) chk("no_warn", 32'h0, {trun, warn});
			if (q) chk("tx_delay", 1, n >= D && n <= D + 8);
			track <= 1'b0;
			if (q) begin
				n = 0;
				while (warn == 6'h00 && n < 40) begin
					@(posedge sys_clk_in);
					n++;
				end
				chk("warn_on", 32'h7f, {trun, warn});
				n = 0;
				while (warn != 6'h00 && n < 300) begin
					@(posedge sys_clk_in);
					n++;
					if (i[0] && n == 5) far <= 1'b1;
				end
				far <= 1'b0;
				if (i[0]) chk("far_end", 1, n >= 8 && n <= 10);
				else chk("cutoff_len", exp_cut(cutoff), n);
				chk("timer_off", 0, {trun, warn});
			end
			repeat (12) @(posedge sys_clk_in);
		end
		// Reset in the middle of a warning must silence every output by the next clock edge
		sound <= 1'b1;
		motion <= 1'b1;
		len <= 8'h14;
		lat <= 4'h0;
		cutoff <= 32'h0000_00c8;
		track <= 1'b1;
		n = 0;
		while (warn == 6'h00 && n < D + 40) begin
			@(posedge sys_clk_in);
			n++;
		end
		chk("warn_on", 32'h7f, {trun, warn});
		track <= 1'b0;
		rst_n_in <= 1'b0;
		repeat (2) @(posedge sys_clk_in);
		chk("reset_quiet", 32'h0, {tx_key, trun, warn});
		rst_n_in <= 1'b1;
		repeat (2) @(posedge sys_clk_in);
		chk("after_reset", 32'h0, {tx_key, trun, warn});
		results();
	end
endmodule : tb_top
